//--- hw/acc_top.sv
// conversion control and status logic of a 10-bit successive approximation converter
//
// Contract
// - any status/control write aborts the running conversion and starts anew unless channel 11111; with hardware trigger on it only re-arms
// - read-only complete flag at bit 7, set at each conversion end without compare
// - with compare on, flag is set only when the compare holds
// - flag clears on status/control write or on a low result read
// - interrupt enable at bit 6 raises the request when the flag sets
// - continuous clear: one conversion per write or per hardware trigger
// - continuous with software trigger: a write starts repeating conversions
// - continuous with hardware trigger: a trigger starts repeating conversions
// - channel chosen by the five-bit field in bits 4 to 0
// - codes 0-27 analog, 11100 reserved, 11101 high ref, 11110 low ref, 11111 off
// - all-ones channel powers the converter off and isolates the input
// - all-ones channel stops continuous conversions with no extra conversion
// - without continuous mode the core drops to low power after each conversion
// - results are right-justified, 10-bit or 8-bit as configured
// - automatic compare against a programmable value, less-than or greater-equal
// - trigger select picks register-write or hardware-input start
// - each hardware trigger pulse starts a conversion when hardware trigger is on; the code ignores pulses while a conversion is running
// - active bit set at start, cleared at completion or abort
// - compare direction bit selects greater-equal instead of less-than
//
// The address map and register access over APB are this design's own decisions.
`timescale 1ns/1ns
`include "acc_params.svh"

module acc_top (
   input wire logic mclk_in,
   input wire logic sys_rst_in,
   // apb slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // trigger source
   input wire logic hardware_trigger_input_in,
   // analog core
   input wire logic core_done_in,
   input wire logic [9:0] core_result_in,
   output logic core_start_out,
   output logic core_abort_out,
   output logic [4:0] core_channel_out,
   output acc_pkg::acc_src_t core_source_out,
   output logic core_power_off_out,
   output logic core_isolate_out,
   output logic core_low_power_out,
   // conversion complete request
   output logic conversion_irq_out
);

   // ***********************************************************
   // apb decode
   // ***********************************************************
   logic setup_phase;
   logic done_phase;
   logic wr_done;
   logic rd_done;
   logic mapped;

   // requests complete at the edge where psel, penable and pready are high
   assign setup_phase = psel_in & ~penable_in;
   assign done_phase = psel_in & penable_in & pready_out;
   assign wr_done = done_phase & pwrite_in;
   assign rd_done = done_phase & ~pwrite_in;
   assign mapped = (paddr_in <= `ACC_OFS_CONFIG) & (paddr_in[1:0] == 2'b00); // dense word map

   logic wr_sc;
   logic wr_c2;
   logic wr_cmpl;
   logic wr_cmph;
   logic wr_cfg;
   logic rd_low;
   assign wr_sc = wr_done & (paddr_in == `ACC_OFS_STATUS_CONTROL);
   assign wr_c2 = wr_done & (paddr_in == `ACC_OFS_CONTROL2);
   assign wr_cmpl = wr_done & (paddr_in == `ACC_OFS_COMPARE_LOW);
   assign wr_cmph = wr_done & (paddr_in == `ACC_OFS_COMPARE_HIGH);
   assign wr_cfg = wr_done & (paddr_in == `ACC_OFS_CONFIG);
   assign rd_low = rd_done & (paddr_in == `ACC_OFS_RESULT_LOW);

   // ***********************************************************
   // registers
   // ***********************************************************
   logic complete_flag;
   logic irq_enable;
   logic continuous_enable;
   logic [4:0] channel_select;
   logic trigger_select;
   logic compare_enable;
   logic compare_ge;
   logic conversion_active;
   logic mode8;
   logic [9:0] compare_value;
   logic [9:0] result;

   // status/control writable fields; channel comes up disabled
   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         irq_enable <= 1'b0;
         continuous_enable <= 1'b0;
         channel_select <= `ACC_RST_CHANNEL;
      end else if (wr_sc) begin
         irq_enable <= pwdata_in[`ACC_BIT_IEN];
         continuous_enable <= pwdata_in[`ACC_BIT_CONT];
         channel_select <= pwdata_in[`ACC_CH_HI:`ACC_CH_LO];
      end
   end

   // second control register writable fields
   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         trigger_select <= 1'b0;
         compare_enable <= 1'b0;
         compare_ge <= 1'b0;
      end else if (wr_c2) begin
         trigger_select <= pwdata_in[`ACC_BIT_TRIG];
         compare_enable <= pwdata_in[`ACC_BIT_CMP_EN];
         compare_ge <= pwdata_in[`ACC_BIT_CMP_GE];
      end
   end

   // compare value and resolution select
   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         compare_value <= 10'h000;
         mode8 <= 1'b0;
      end else begin
         if (wr_cmpl) begin
            compare_value[7:0] <= pwdata_in[7:0];
         end
         if (wr_cmph) begin
            compare_value[9:8] <= pwdata_in[1:0];
         end
         if (wr_cfg) begin
            mode8 <= pwdata_in[`ACC_BIT_MODE8];
         end
      end
   end

   // ***********************************************************
   // conversion sequencer
   // ***********************************************************
   acc_pkg::acc_state_t state;
   logic armed;
   logic repeat_run;
   logic trig_prev;
   logic trig_pulse;
   logic ch_off;
   logic sw_start;
   logic hw_start;
   logic start_now;
   logic conv_end;

   assign ch_off = (channel_select == `ACC_CH_DISABLED);
   // each rising edge of the trigger counts as one trigger pulse
   assign trig_pulse = hardware_trigger_input_in & ~trig_prev;
   // write with a usable channel in software mode starts at once
   assign sw_start = wr_sc & ~trigger_select &
      (pwdata_in[`ACC_CH_HI:`ACC_CH_LO] != `ACC_CH_DISABLED);
   // hardware trigger starts when armed by a write and not busy
   assign hw_start = trigger_select & armed & ~ch_off & trig_pulse &
      (state == acc_pkg::ACC_IDLE) & ~wr_sc;
   assign conv_end = (state == acc_pkg::ACC_BUSY) & core_done_in & ~wr_sc;
   // continuous runs chain the next start straight off the end
   assign start_now = sw_start | hw_start | (conv_end & repeat_run & ~ch_off);

   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         trig_prev <= 1'b0;
      end else begin
         trig_prev <= hardware_trigger_input_in;
      end
   end

   // sequencer state: a write aborts whatever is under way
   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         state <= acc_pkg::ACC_IDLE;
      end else if (start_now) begin
         state <= acc_pkg::ACC_BUSY;
      end else if (wr_sc | conv_end) begin
         state <= acc_pkg::ACC_IDLE;
      end
   end

   // armed: hardware mode waits for triggers after a write with a usable channel
   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         armed <= 1'b0;
      end else if (wr_sc) begin
         armed <= (pwdata_in[`ACC_CH_HI:`ACC_CH_LO] != `ACC_CH_DISABLED);
      end
   end

   // repeat flag: set by a continuous start, cleared by a write that stops it
   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         repeat_run <= 1'b0;
      end else if (wr_sc) begin
         repeat_run <= sw_start & pwdata_in[`ACC_BIT_CONT];
      end else if (hw_start) begin
         repeat_run <= continuous_enable;
      end else if (ch_off) begin
         repeat_run <= 1'b0;
      end
   end

   // active bit follows start and end or abort
   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         conversion_active <= 1'b0;
      end else begin
         conversion_active <= start_now | ((state == acc_pkg::ACC_BUSY) &
            ~core_done_in & ~wr_sc);
      end
   end

   // ***********************************************************
   // result, compare and completion flag
   // ***********************************************************
   logic [9:0] fmt_result;
   logic [9:0] cmp_ref;
   logic cmp_less;
   logic cmp_true;
   logic accept;

   // 8-bit mode keeps the upper eight bits, right-justified
   assign fmt_result = mode8 ? {2'b00, core_result_in[9:2]} : core_result_in;
   assign cmp_ref = mode8 ? {2'b00, compare_value[7:0]} : compare_value;
   assign cmp_less = (fmt_result < cmp_ref);
   assign cmp_true = compare_ge ? ~cmp_less : cmp_less;
   assign accept = conv_end & (~compare_enable | cmp_true);

   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         result <= 10'h000;
      end else if (accept) begin
         result <= fmt_result;
      end
   end

   // flag: a completion in the same cycle as a low result read wins; a status/control write suppresses the completion
   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         complete_flag <= 1'b0;
      end else if (accept) begin
         complete_flag <= 1'b1;
      end else if (wr_sc | rd_low) begin
         complete_flag <= 1'b0;
      end
   end

   // request level while flag and enable both stand
   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         conversion_irq_out <= 1'b0;
      end else begin
         conversion_irq_out <= complete_flag & irq_enable;
      end
   end

   // ***********************************************************
   // analog core controls
   // ***********************************************************
   acc_pkg::acc_src_t next_source;
   logic [4:0] next_channel;

   // the core gets a written channel together with its start pulse, never a stale one
   assign next_channel = wr_sc ? pwdata_in[`ACC_CH_HI:`ACC_CH_LO] : channel_select;
   assign next_source = (next_channel == `ACC_CH_DISABLED) ? acc_pkg::ACC_SRC_OFF :
      (next_channel == `ACC_CH_LOW_REF) ? acc_pkg::ACC_SRC_LOW_REF :
      (next_channel == `ACC_CH_HIGH_REF) ? acc_pkg::ACC_SRC_HIGH_REF :
      (next_channel == `ACC_CH_RESERVED) ? acc_pkg::ACC_SRC_RESERVED : acc_pkg::ACC_SRC_ANALOG;

   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         core_start_out <= 1'b0;
         core_abort_out <= 1'b0;
         core_channel_out <= `ACC_RST_CHANNEL;
         core_source_out <= acc_pkg::ACC_SRC_OFF;
         core_power_off_out <= 1'b1;
         core_isolate_out <= 1'b1;
         core_low_power_out <= 1'b1;
      end else begin
         core_start_out <= start_now;
         core_abort_out <= wr_sc & (state == acc_pkg::ACC_BUSY);
         core_channel_out <= next_channel;
         core_source_out <= next_source;
         core_power_off_out <= (next_channel == `ACC_CH_DISABLED);
         core_isolate_out <= (next_channel == `ACC_CH_DISABLED);
         // idle and not repeating means low power
         core_low_power_out <= ~start_now & ((state == acc_pkg::ACC_IDLE) |
            (conv_end & ~repeat_run));
      end
   end

   // ***********************************************************
   // apb answer
   // ***********************************************************
   logic [31:0] next_rdata;

   always_comb begin
      unique case (paddr_in)
         `ACC_OFS_STATUS_CONTROL: next_rdata = {24'h000000, complete_flag, irq_enable,
            continuous_enable, channel_select};
         `ACC_OFS_CONTROL2: next_rdata = {24'h000000, conversion_active, trigger_select,
            compare_enable, compare_ge, 4'h0};
         `ACC_OFS_RESULT_LOW: next_rdata = {24'h000000, result[7:0]};
         `ACC_OFS_RESULT_HIGH: next_rdata = {30'h00000000, result[9:8]};
         `ACC_OFS_COMPARE_LOW: next_rdata = {24'h000000, compare_value[7:0]};
         `ACC_OFS_COMPARE_HIGH: next_rdata = {30'h00000000, compare_value[9:8]};
         `ACC_OFS_CONFIG: next_rdata = {31'h00000000, mode8};
         default: next_rdata = 32'h00000000;
      endcase
   end

   // one wait-free access cycle: pready rises in the first access cycle
   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         pready_out <= 1'b0;
         pslverr_out <= 1'b0;
         prdata_out <= 32'h00000000;
      end else begin
         pready_out <= setup_phase;
         pslverr_out <= setup_phase & ~mapped;
         if (setup_phase & ~pwrite_in) begin
            prdata_out <= next_rdata;
         end
      end
   end

endmodule

//--- hw/acc_params.svh
// constants for the conversion control block: offsets, bit positions, resets
`ifndef ACC_PARAMS_SVH
`define ACC_PARAMS_SVH

// byte offsets of the registers on the apb slave
`define ACC_OFS_STATUS_CONTROL 12'h000
`define ACC_OFS_CONTROL2 12'h004
`define ACC_OFS_RESULT_LOW 12'h008
`define ACC_OFS_RESULT_HIGH 12'h00c
`define ACC_OFS_COMPARE_LOW 12'h010
`define ACC_OFS_COMPARE_HIGH 12'h014
`define ACC_OFS_CONFIG 12'h018

// status/control field positions
`define ACC_BIT_COMPLETE 7
`define ACC_BIT_IEN 6
`define ACC_BIT_CONT 5
`define ACC_CH_HI 4
`define ACC_CH_LO 0

// second control register field positions
`define ACC_BIT_ACTIVE 7
`define ACC_BIT_TRIG 6
`define ACC_BIT_CMP_EN 5
`define ACC_BIT_CMP_GE 4

// config register: bit set selects 8-bit results
`define ACC_BIT_MODE8 0

// channel codes
`define ACC_CH_LAST_ANALOG 5'h1b
`define ACC_CH_RESERVED 5'h1c
`define ACC_CH_HIGH_REF 5'h1d
`define ACC_CH_LOW_REF 5'h1e
`define ACC_CH_DISABLED 5'h1f

// reset values
`define ACC_RST_CHANNEL 5'h1f
`define ACC_RST_BYTE 8'h00

`endif

//--- hw/acc_pkg.sv
// types shared by the conversion control block
package acc_pkg;
   // conversion sequencer states
   typedef enum logic [0:0] {
      ACC_IDLE,
      ACC_BUSY
   } acc_state_t;

   // kind of source the channel code selects
   typedef enum logic [2:0] {
      ACC_SRC_ANALOG,
      ACC_SRC_RESERVED,
      ACC_SRC_HIGH_REF,
      ACC_SRC_LOW_REF,
      ACC_SRC_OFF
   } acc_src_t;
endpackage

//--- tb/acc_core_model.sv
// behavioural analog core that answers start pulses after a set delay
`timescale 1ns/1ns
module acc_core_model (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic start_in,
   input wire logic abort_in,
   input wire logic [4:0] channel_in,
   input wire logic [7:0] delay_in,
   output logic done_out,
   output logic [9:0] result_out
);
   logic [7:0] cnt;
   // count down from each start; an abort drops the job, a restart reloads
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         cnt <= 8'h00;
         done_out <= 1'b0;
         result_out <= 10'h155;
      end else begin
         done_out <= 1'b0;
         result_out <= ~result_out; // no stale result outside the done pulse
         if (start_in) begin
            cnt <= delay_in;
         end else if (abort_in) begin
            cnt <= 8'h00;
         end else if (cnt == 8'h01) begin
            cnt <= 8'h00;
            done_out <= 1'b1;
            result_out <= {channel_in, 5'h0b};
         end else if (cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
         end
      end
   end
endmodule

//--- tb/acc_top_chk.sv
// port assertions for the conversion control block
`timescale 1ns/1ns
module acc_top_chk (
   input wire logic mclk_in,
   input wire logic sys_rst_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic pready_out,
   input wire logic hardware_trigger_input_in,
   input wire logic core_done_in,
   input wire logic core_start_out,
   input wire logic core_abort_out,
   input wire logic [4:0] core_channel_out,
   input wire acc_pkg::acc_src_t core_source_out,
   input wire logic core_power_off_out,
   input wire logic core_isolate_out,
   input wire logic core_low_power_out,
   input wire logic conversion_irq_out
);
   // ****
   // completed status writes and low result reads
   // ****
   logic acc_wr0;
   logic acc_rd8;
   assign acc_wr0 = psel_in & penable_in & pready_out & pwrite_in & (paddr_in == 12'h000);
   assign acc_rd8 = psel_in & penable_in & pready_out & !pwrite_in & (paddr_in == 12'h008);
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (sys_rst_in);
   property p_abort; core_abort_out |-> $past(acc_wr0); endproperty
   a_abort: assert property (p_abort) else $error("abort without status write");
   property p_start;
      core_start_out |-> $past(acc_wr0) || core_done_in || $past(core_done_in)
         || $past(hardware_trigger_input_in) || $past(hardware_trigger_input_in, 2);
   endproperty
   a_start: assert property (p_start) else $error("start without cause");
   property p_off;
      core_channel_out == 5'h1f |-> core_power_off_out && core_isolate_out && !core_start_out;
   endproperty
   a_off: assert property (p_off) else $error("disabled channel not off");
   property p_lowp; core_start_out |-> !core_low_power_out; endproperty
   a_lowp: assert property (p_lowp) else $error("low power while starting");
   property p_irq_rise; $rose(conversion_irq_out) |-> $past(core_done_in, 2); endproperty
   a_irq_rise: assert property (p_irq_rise) else $error("request without completion");
   property p_irq_wr; acc_wr0 |-> ##2 !conversion_irq_out; endproperty
   a_irq_wr: assert property (p_irq_wr) else $error("request kept after write");
   property p_irq_rd; acc_rd8 && !core_done_in |-> ##2 !conversion_irq_out; endproperty
   a_irq_rd: assert property (p_irq_rd) else $error("request kept after read");
   property p_src;
      core_source_out == (core_channel_out <= 5'h1b ? acc_pkg::ACC_SRC_ANALOG
         : core_channel_out == 5'h1c ? acc_pkg::ACC_SRC_RESERVED
         : core_channel_out == 5'h1d ? acc_pkg::ACC_SRC_HIGH_REF
         : core_channel_out == 5'h1e ? acc_pkg::ACC_SRC_LOW_REF : acc_pkg::ACC_SRC_OFF);
   endproperty
   a_src: assert property (p_src) else $error("channel decode wrong");
   property p_ready; psel_in && !penable_in |=> pready_out; endproperty
   a_ready: assert property (p_ready) else $error("no ready in access cycle");
endmodule
bind acc_top acc_top_chk acc_top_chk_i (.*);

//--- tb/tb_top.sv
// self-checking bench for the conversion control block
`timescale 1ns/1ns
module tb_top;
   // ****
   // signals, clock, instances
   // ****
   logic mclk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic psel_in = 1'b0;
   logic penable_in = 1'b0;
   logic pwrite_in = 1'b0;
   logic [11:0] paddr_in = 12'h000;
   logic [31:0] pwdata_in = 32'h0;
   logic hardware_trigger_input_in = 1'b0;
   logic [7:0] dly = 8'h03;
   logic core_done_in, pready_out, pslverr_out, core_start_out, core_abort_out;
   logic core_power_off_out, core_isolate_out, core_low_power_out, conversion_irq_out;
   logic [9:0] core_result_in;
   logic [4:0] core_channel_out;
   logic [31:0] prdata_out, q;
   acc_pkg::acc_src_t core_source_out;
   logic err;
   int error_cnt = 0, n_checks = 0, n_start = 0, n_abort = 0, s0;
   always #10 mclk_in = ~mclk_in;
   acc_top acc_top_i (.*);
   acc_core_model acc_core_model_i (.clk_in(mclk_in), .rst_in(sys_rst_in),
      .start_in(core_start_out), .abort_in(core_abort_out), .channel_in(core_channel_out),
      .delay_in(dly), .done_out(core_done_in), .result_out(core_result_in));
   // count start and abort pulses
   always @(posedge mclk_in) begin
      if (core_start_out === 1'b1) n_start++;
      if (core_abort_out === 1'b1) n_abort++;
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge mclk_in);
      psel_in <= 1'b1;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge mclk_in);
      penable_in <= 1'b1;
      // wait for the answer however long it takes; only the watchdog ends this
      do begin
         @(posedge mclk_in);
      end while (pready_out !== 1'b1);
      q = prdata_out;
      err = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
   endtask
   task rd(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(q, exp);
   endtask
   task wait_done;
      int i;
      for (i = 0; i < 200; i++) begin
         @(posedge mclk_in);
         if (core_done_in === 1'b1) break;
      end
   endtask
   // ****
   // scenarios
   // ****
   task t_single;
      apb(1'b1, 12'h000, 32'h03);
      wait_done;
      chk(core_channel_out, 32'h03);
      rd(12'h000, 32'h83);
      chk(core_low_power_out, 32'h1);
      s0 = n_start;
      rd(12'h008, 32'h6b);
      rd(12'h00c, 32'h00);
      rd(12'h000, 32'h03);
      repeat (20) @(posedge mclk_in);
      chk(n_start - s0, 32'h0);
   endtask
   task t_irq;
      apb(1'b1, 12'h000, 32'h45);
      wait_done;
      repeat (2) @(posedge mclk_in);
      chk(conversion_irq_out, 32'h1);
      rd(12'h008, 32'h ab);
      repeat (2) @(posedge mclk_in);
      chk(conversion_irq_out, 32'h0);
   endtask
   task t_abort;
      dly <= 8'h14;
      apb(1'b1, 12'h000, 32'h02);
      s0 = n_abort;
      rd(12'h004, 32'h80);
      apb(1'b1, 12'h000, 32'h04);
      wait_done;
      chk(n_abort - s0, 32'h1);
      rd(12'h008, 32'h8b);
      dly <= 8'h03;
   endtask
   task t_cont;
      s0 = n_start;
      apb(1'b1, 12'h000, 32'h27);
      repeat (40) @(posedge mclk_in);
      chk(n_start - s0 >= 5, 32'h1);
      apb(1'b1, 12'h000, 32'h1f);
      repeat (2) @(posedge mclk_in);
      s0 = n_start;
      repeat (20) @(posedge mclk_in);
      chk(n_start - s0, 32'h0);
      chk({core_power_off_out, core_isolate_out}, 32'h3);
   endtask
   task t_cmp;
      apb(1'b1, 12'h004, 32'h20);
      apb(1'b1, 12'h010, 32'h00);
      apb(1'b1, 12'h014, 32'h00);
      apb(1'b1, 12'h000, 32'h06);
      wait_done;
      rd(12'h000, 32'h06);
      apb(1'b1, 12'h004, 32'h30);
      apb(1'b1, 12'h000, 32'h06);
      wait_done;
      rd(12'h000, 32'h86);
      rd(12'h004, 32'h30);
      apb(1'b1, 12'h004, 32'h00);
   endtask
   // software sequence for a temperature reading: bandgap first, then the sensor
   task t_temp;
      apb(1'b1, 12'h000, 32'h1b);
      wait_done;
      rd(12'h008, 32'h6b);
      rd(12'h00c, 32'h03);
      apb(1'b1, 12'h000, 32'h1a);
      wait_done;
      rd(12'h008, 32'h4b);
   endtask
   task t_hw;
      apb(1'b1, 12'h018, 32'h01);
      apb(1'b1, 12'h004, 32'h40);
      s0 = n_start;
      apb(1'b1, 12'h000, 32'h08);
      repeat (5) @(posedge mclk_in);
      chk(n_start - s0, 32'h0);
      @(posedge mclk_in);
      hardware_trigger_input_in <= 1'b1;
      @(posedge mclk_in);
      hardware_trigger_input_in <= 1'b0;
      wait_done;
      rd(12'h000, 32'h88);
      rd(12'h008, 32'h42);
      apb(1'b0, 12'hffc, 32'h0);
      chk(err, 32'h1);
      // continuous runs in hardware mode start on one trigger edge
      s0 = n_start;
      apb(1'b1, 12'h000, 32'h28);
      @(posedge mclk_in);
      hardware_trigger_input_in <= 1'b1;
      @(posedge mclk_in);
      hardware_trigger_input_in <= 1'b0;
      repeat (40) @(posedge mclk_in);
      chk(n_start - s0 >= 5, 32'h1);
      apb(1'b1, 12'h000, 32'h1f);
   endtask
   task results;
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // main sequence after reset
   initial begin
      repeat (10) @(posedge mclk_in);
      sys_rst_in <= 1'b0;
      rd(12'h000, 32'h1f);
      chk(core_low_power_out, 32'h1);
      t_single;
      t_irq;
      t_abort;
      t_cont;
      t_cmp;
      t_temp;
      t_hw;
      results;
   end
   // watchdog well beyond the expected run
   initial begin
      #400000;
      error_cnt++;
      results;
   end
endmodule
